// ==== logic/dpgm_port.sv ====
// Two-port pin multiplexer with its special function registers
`timescale 1ns/1ns
`default_nettype none
`include "dpgm_params.svh"
// Notes on behaviour
// R01 - Reset makes every first-port pin input
// R02 - Reset sets second port as SPI master
// R03 - Reset configuration holds until software writes
// R04 - Alternate select overrides direction, first port
// R05 - UART receive pin still follows direction bit
// R06 - Fixed alternate function per first-port pin
// R07 - Interrupt inputs pass only when selected
// R08 - Timer zero/one inputs sampled every four clocks
// R09 - Unselected first-port pin is plain GPIO
// R10 - Direction bit zero output, one input
// R11 - Drive bit: odd pins source, even sink
// R12 - Second port registers keep four bits
// R13 - Routing 01 makes second port SPI master
// R14 - Otherwise GPIO, alternate overrides direction
// R15 - Alternate bit zero gives timer two input
// R16 - Second-port pin two always input
// R17 - Second-port pin three forced output under routing 01
// R18 - Pins one and three follow direction except under routing 01
// R19 - Latch drives only GPIO outputs; reads pins
module dpgm_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] spi_route,
  input wire logic [7:0] p0_pin_in,
  input wire logic [3:0] p1_pin_in,
  output dpgm_pkg::dpgm_p0_pins_t p0_pins,
  output dpgm_pkg::dpgm_p1_pins_t p1_pins,
  input wire dpgm_pkg::dpgm_periph_out_t periph_out,
  output dpgm_pkg::dpgm_periph_in_t periph_in
);
  import dpgm_pkg::*;

  // ========================================================================
  // Registers
  logic [7:0] port_zero_data;
  logic [3:0] port_one_data;
  logic [7:0] port_zero_high_drive;
  logic [7:0] port_zero_direction;
  logic [7:0] port_zero_function_select;
  logic [3:0] port_one_direction;
  logic [3:0] port_one_function_select;
  logic [7:0] next_p0_data;
  logic [3:0] next_p1_data;
  logic [7:0] next_p0_drive;
  logic [7:0] next_port_zero_direction;
  logic [7:0] next_p0_fsel;
  logic [3:0] next_port_one_direction;
  logic [3:0] next_p1_fsel;

  // Only a write changes configuration; nothing else touches it
  always_comb begin
    next_p0_data = port_zero_data;
    next_p1_data = port_one_data;
    next_p0_drive = port_zero_high_drive;
    next_port_zero_direction = port_zero_direction;
    next_p0_fsel = port_zero_function_select;
    next_port_one_direction = port_one_direction;
    next_p1_fsel = port_one_function_select;
    if (sfr_wr) begin // R03
      unique case (sfr_addr)
        `DPGM_ADDR_P0_DATA: next_p0_data = sfr_wdata;
        `DPGM_ADDR_P1_DATA: next_p1_data = sfr_wdata[3:0]; // R12
        `DPGM_ADDR_P0_DRIVE: next_p0_drive = sfr_wdata;
        `DPGM_ADDR_PORT_ZERO_DIRECTION: next_port_zero_direction = sfr_wdata;
        `DPGM_ADDR_P0_FSEL: next_p0_fsel = sfr_wdata;
        `DPGM_ADDR_PORT_ONE_DIRECTION: next_port_one_direction = sfr_wdata[3:0]; // R12
        `DPGM_ADDR_P1_FSEL: next_p1_fsel = sfr_wdata[3:0]; // R12
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_zero_data <= `DPGM_RST_P0_DATA;
      port_one_data <= `DPGM_RST_P1_DATA;
      port_zero_high_drive <= `DPGM_RST_P0_DRIVE;
      port_zero_direction <= `DPGM_RST_PORT_ZERO_DIRECTION; // R01
      port_zero_function_select <= `DPGM_RST_P0_FSEL;
      port_one_direction <= `DPGM_RST_PORT_ONE_DIRECTION;
      port_one_function_select <= `DPGM_RST_P1_FSEL;
    end else begin
      port_zero_data <= next_p0_data;
      port_one_data <= next_p1_data;
      port_zero_high_drive <= next_p0_drive;
      port_zero_direction <= next_port_zero_direction;
      port_zero_function_select <= next_p0_fsel;
      port_one_direction <= next_port_one_direction;
      port_one_function_select <= next_p1_fsel;
    end
  end

  // ========================================================================
  // Pin synchronisers
  logic [7:0] p0_meta;
  logic [7:0] p0_sync;
  logic [3:0] p1_meta;
  logic [3:0] p1_sync;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p0_meta <= 8'h00;
      p0_sync <= 8'h00;
      p1_meta <= 4'h0;
      p1_sync <= 4'h0;
    end else begin
      p0_meta <= p0_pin_in;
      p0_sync <= p0_meta;
      p1_meta <= p1_pin_in;
      p1_sync <= p1_meta;
    end
  end

  // ========================================================================
  // Pin direction and source
  // Direction: 0 output, 1 input
  function automatic logic is_out(input logic dir_bit);
    is_out = ~dir_bit; // R10
  endfunction : is_out

  logic [7:0] next_p0_oe;
  logic [7:0] next_p0_out;
  logic [3:0] next_p1_oe;
  logic [3:0] next_p1_out;
  logic [7:0] port_zero_function_select_out;
  logic [7:0] port_zero_function_select_oe;
  logic boot_spi;

  always_comb begin
    // Fixed alternate assignment of each first-port pin
    port_zero_function_select_out = {periph_out.pwm, 3'b000, 3'b000,
                  periph_out.general_timer_output}; // R06
    port_zero_function_select_out[2] = periph_out.uart_txd; // R06
    port_zero_function_select_oe = 8'h85; // R06
    // Receive pin keeps its own direction bit
    port_zero_function_select_oe[1] = is_out(port_zero_direction[1]); // R05
    port_zero_function_select_out[1] = port_zero_data[1]; // R05
    for (int i = 0; i < 8; i++) begin
      if (port_zero_function_select[i]) begin // R04
        next_p0_oe[i] = port_zero_function_select_oe[i];
        next_p0_out[i] = port_zero_function_select_out[i];
      end else begin // R09
        next_p0_oe[i] = is_out(port_zero_direction[i]);
        next_p0_out[i] = port_zero_data[i]; // R19
      end
    end

    boot_spi = (spi_route == `DPGM_SPI_ROUTE_BOOT);
    next_p1_out = port_one_data; // R19
    next_p1_oe = {is_out(port_one_direction[3]), 1'b0,
                  is_out(port_one_direction[1]),
                  is_out(port_one_direction[0])}; // R18
    if (boot_spi) begin // R13
      next_p1_oe[`DPGM_P1_SCK] = 1'b1;
      next_p1_oe[`DPGM_P1_MOSI] = 1'b1;
      next_p1_out[`DPGM_P1_SCK] = periph_out.spi_sck;
      next_p1_out[`DPGM_P1_MOSI] = periph_out.spi_mosi;
      next_p1_oe[`DPGM_P1_CS] = 1'b1; // R17
    end else if (port_one_function_select[0]) begin // R14
      next_p1_oe[`DPGM_P1_SCK] = 1'b0; // R15
    end
    next_p1_oe[`DPGM_P1_MISO] = 1'b0; // R16
  end

  // ========================================================================
  // Registered pin outputs
  logic [7:0] src_hi;
  logic [7:0] snk_hi;
  always_comb begin
    src_hi = port_zero_high_drive & 8'haa; // R11
    snk_hi = port_zero_high_drive & 8'h55; // R11
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      p0_pins <= '0; // R01
      p1_pins.out <= `DPGM_RST_P1_DATA;
      p1_pins.oe <= 4'hb; // R02
    end else begin
      p0_pins.out <= next_p0_out;
      p0_pins.oe <= next_p0_oe;
      p0_pins.src_hi <= src_hi;
      p0_pins.snk_hi <= snk_hi;
      p1_pins.out <= next_p1_out;
      p1_pins.oe <= next_p1_oe;
    end
  end

  // ========================================================================
  // Inputs towards peripherals
  logic [2:0] tmr_raw;
  logic [2:0] tmr_smp;
  always_comb begin
    tmr_raw = {p1_sync[`DPGM_P1_SCK] & port_one_function_select[0]
               & ~boot_spi, // R15
               p0_sync[6] & port_zero_function_select[6],
               p0_sync[5] & port_zero_function_select[5]};
  end

  // Timers see inputs only at the slow sample point
  dpgm_sampler #(
    .WIDTH(3),
    .PERIOD(`DPGM_SAMPLE_PERIOD)
  ) u_sampler (
    .clk(clk),
    .rst_n(rst_n),
    .din(tmr_raw),
    .dout(tmr_smp)
  ); // R08

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      periph_in <= '0;
      periph_in.external_interrupt_zero <= 1'b1;
      periph_in.external_interrupt_one <= 1'b1;
    end else begin
      periph_in.spi_miso <= p1_sync[`DPGM_P1_MISO];
      periph_in.uart_rxd <= p0_sync[1] | ~port_zero_function_select[1];
      // Interrupts are active low, so idle high when not selected
      periph_in.external_interrupt_zero <= p0_sync[3]
        | ~port_zero_function_select[3]; // R07
      periph_in.external_interrupt_one <= p0_sync[4]
        | ~port_zero_function_select[4]; // R07
      periph_in.timer_zero_input <= tmr_smp[0];
      periph_in.timer_one_input <= tmr_smp[1];
      periph_in.timer_two_input <= tmr_smp[2];
    end
  end

  // ========================================================================
  // Register read
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_rd) begin
      unique case (sfr_addr)
        `DPGM_ADDR_P0_DATA: next_rdata = p0_sync; // R19
        `DPGM_ADDR_P1_DATA: next_rdata = {4'h0, p1_sync}; // R19
        `DPGM_ADDR_P0_DRIVE: next_rdata = port_zero_high_drive;
        `DPGM_ADDR_PORT_ZERO_DIRECTION: next_rdata = port_zero_direction;
        `DPGM_ADDR_P0_FSEL: next_rdata = port_zero_function_select;
        `DPGM_ADDR_PORT_ONE_DIRECTION: next_rdata = {4'h0, port_one_direction};
        `DPGM_ADDR_P1_FSEL: next_rdata = {4'h0, port_one_function_select};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else begin
      sfr_rdata <= next_rdata;
    end
  end
endmodule : dpgm_port
`default_nettype wire

// ==== shared/dpgm_params.svh ====
// Offsets, reset values, field positions and timing counts of the port block
`ifndef DPGM_PARAMS_SVH
`define DPGM_PARAMS_SVH
// ==========================================================================
// Register offsets
`define DPGM_ADDR_P0_DATA 8'h80
`define DPGM_ADDR_P1_DATA 8'h90
`define DPGM_ADDR_P0_DRIVE 8'h93
`define DPGM_ADDR_PORT_ZERO_DIRECTION 8'h94
`define DPGM_ADDR_P0_FSEL 8'h95
`define DPGM_ADDR_PORT_ONE_DIRECTION 8'h96
`define DPGM_ADDR_P1_FSEL 8'h97
// ==========================================================================
// Reset values
`define DPGM_RST_P0_DATA 8'hff
`define DPGM_RST_P1_DATA 4'hf
`define DPGM_RST_P0_DRIVE 8'h00
`define DPGM_RST_PORT_ZERO_DIRECTION 8'hff
`define DPGM_RST_P0_FSEL 8'h00
`define DPGM_RST_PORT_ONE_DIRECTION 4'h4
`define DPGM_RST_P1_FSEL 4'h0
// ==========================================================================
// Fields and timing
`define DPGM_SPI_ROUTE_BOOT 2'h1
`define DPGM_SAMPLE_PERIOD 4
`define DPGM_P1_SCK 0
`define DPGM_P1_MOSI 1
`define DPGM_P1_MISO 2
`define DPGM_P1_CS 3
`endif

// ==== shared/dpgm_pkg.sv ====
// Types shared by the port block
`default_nettype none
package dpgm_pkg;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] src_hi;
    logic [7:0] snk_hi;
  } dpgm_p0_pins_t;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } dpgm_p1_pins_t;
  typedef struct packed {
    logic spi_sck;
    logic spi_mosi;
    logic general_timer_output;
    logic uart_txd;
    logic pwm;
  } dpgm_periph_out_t;
  typedef struct packed {
    logic spi_miso;
    logic uart_rxd;
    logic external_interrupt_zero;
    logic external_interrupt_one;
    logic timer_zero_input;
    logic timer_one_input;
    logic timer_two_input;
  } dpgm_periph_in_t;
endpackage : dpgm_pkg
`default_nettype wire

// ==== logic/dpgm_sampler.sv ====
// Divide-by-N strobe sampler for timer control inputs
`timescale 1ns/1ns
`default_nettype none
module dpgm_sampler #(
  parameter int WIDTH = 3,
  parameter int PERIOD = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  // Counter is eight bits wide, so longer periods cannot be served
  if (PERIOD < 1 || PERIOD > 256 || WIDTH < 1) begin : g_bad_param
    $error("dpgm_sampler: PERIOD or WIDTH out of range");
  end
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [WIDTH-1:0] next_dout;
  always_comb begin
    next_cnt = (cnt == 8'(PERIOD - 1)) ? 8'h00 : cnt + 8'h01;
    next_dout = (cnt == 8'(PERIOD - 1)) ? din : dout;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      dout <= '0;
    end else begin
      cnt <= next_cnt;
      dout <= next_dout;
    end
  end
endmodule : dpgm_sampler
`default_nettype wire

// ==== tb/dpgm_board.sv ====
// Board model: pins resolved between device drivers and board levels
`timescale 1ns/1ns
`default_nettype none
module dpgm_board (
  input wire dpgm_pkg::dpgm_p0_pins_t p0_pins,
  input wire dpgm_pkg::dpgm_p1_pins_t p1_pins,
  input wire logic [7:0] ext0,
  input wire logic [3:0] ext1,
  output logic [7:0] p0_pin_in,
  output logic [3:0] p1_pin_in
);
  import dpgm_pkg::*;
  // ====================
  // Wire level
  // Undriven pins show the board level, never the last driven value
  assign p0_pin_in = (p0_pins.oe & p0_pins.out) | (~p0_pins.oe & ext0);
  assign p1_pin_in = (p1_pins.oe & p1_pins.out) | (~p1_pins.oe & ext1);
endmodule : dpgm_board
`default_nettype wire

// ==== tb/dpgm_port_properties.sv ====
// Checker for the two-port pin multiplexer
`timescale 1ns/1ns
`default_nettype none
module dpgm_port_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic [1:0] spi_route,
  input wire dpgm_pkg::dpgm_p0_pins_t p0_pins,
  input wire dpgm_pkg::dpgm_p1_pins_t p1_pins,
  input wire dpgm_pkg::dpgm_periph_in_t periph_in
);
  import dpgm_pkg::*;
  // ====================
  // Register mirror
  logic [7:0] dir, fsel, drv, dat;
  logic [3:0] dir1, fsel1, quiet;
  logic [1:0] route_q;
  wire logic [7:0] oe0 = (fsel & 8'h85) | (~dir & ~(fsel & 8'hfd));
  wire logic [3:0] oe1 = (route_q == 2'h1) ? 4'hb :
    {~dir1[3], 1'b0, ~dir1[1], ~dir1[0] & ~fsel1[0]};
  // Quiet counts edges since the last change of configuration
  always_ff @(posedge clk) begin
    route_q <= spi_route;
    quiet <= (!rst_n || sfr_wr || spi_route != route_q) ? 4'h0 :
      quiet + {3'h0, quiet != 4'hf};
    if (!rst_n) begin
      {dir, fsel, drv, dat} <= 32'hff00_00ff;
      {dir1, fsel1} <= 8'h40;
    end else if (sfr_wr) begin
      case (sfr_addr)
        8'h80: dat <= sfr_wdata;
        8'h93: drv <= sfr_wdata;
        8'h94: dir <= sfr_wdata;
        8'h95: fsel <= sfr_wdata;
        8'h96: dir1 <= sfr_wdata[3:0];
        8'h97: fsel1 <= sfr_wdata[3:0];
        default: ;
      endcase
    end
  end
  // ====================
  // Properties
  default clocking dc @(posedge clk);
  endclocking
  a_reset_p0_input: assert property (
    !rst_n |=> p0_pins.oe == 8'h00) else $error("p0 driven in reset");
  a_reset_p1_master: assert property (
    !rst_n |=> p1_pins.oe == 4'hb) else $error("p1 not master in reset");
  a_port_zero_direction_oe: assert property (disable iff (!rst_n)
    quiet > 4'h0 |-> p0_pins.oe == oe0) else $error("p0 direction");
  a_p0_gpio_out: assert property (disable iff (!rst_n)
    quiet > 4'h0 |-> (p0_pins.out & oe0 & ~fsel) == (dat & oe0 & ~fsel))
    else $error("p0 latch not on pins");
  a_drive_split: assert property (disable iff (!rst_n)
    quiet > 4'h0 |-> ((p0_pins.src_hi ^ (drv & 8'haa)) & p0_pins.oe) == 0
    && ((p0_pins.snk_hi ^ (drv & 8'h55)) & p0_pins.oe) == 0)
    else $error("drive strength");
  a_miso_input: assert property (disable iff (!rst_n)
    !p1_pins.oe[2]) else $error("p1 pin 2 driven");
  a_port_one_direction_oe: assert property (disable iff (!rst_n)
    quiet > 4'h0 |-> p1_pins.oe == oe1) else $error("p1 direction");
  a_int_gate: assert property (disable iff (!rst_n)
    quiet > 4'h3 && !fsel[3] |-> periph_in.external_interrupt_zero)
    else $error("interrupt passed");
  a_timer_rate: assert property (disable iff (!rst_n)
    quiet > 4'h7 && fsel[5] && $changed(periph_in.timer_zero_input) |=>
    $stable(periph_in.timer_zero_input)[*3]) else $error("timer rate");
  a_p1_rd_upper: assert property (disable iff (!rst_n)
    sfr_rd && (sfr_addr == 8'h90 || sfr_addr == 8'h96 || sfr_addr == 8'h97)
    |=> sfr_rdata[7:4] == 4'h0) else $error("p1 upper bits");
endmodule : dpgm_port_properties
bind dpgm_port dpgm_port_properties chk (.clk, .rst_n, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .spi_route, .p0_pins, .p1_pins,
  .periph_in);
`default_nettype wire

// ==== tb/tb_dual_port_gpio_mux.sv ====
// Self-checking bench for the two-port pin multiplexer
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t got %h want %h", $time, a, b); end end
module tb_dual_port_gpio_mux;
  import dpgm_pkg::*;
  logic clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, rd_q = 0;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, ext0 = 0, v, dv, m;
  logic [7:0] p0_pin_in, g;
  logic [3:0] ext1 = 0, p1_pin_in;
  logic [1:0] spi_route = 0;
  dpgm_p0_pins_t p0_pins;
  dpgm_p1_pins_t p1_pins;
  dpgm_periph_out_t periph_out = '0;
  dpgm_periph_in_t periph_in;
  logic [7:0] notes[$];
  logic [7:0] ra[8] = '{8'h80, 8'h90, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97,
    8'h91};
  logic [7:0] rv[8] = '{8'h00, 8'h0b, 8'h00, 8'hff, 8'h00, 8'h04, 8'h00,
    8'h00};
  int failures = 0, checked = 0, seed = 23, i;
  dpgm_port DUT (.clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .spi_route, .p0_pin_in, .p1_pin_in, .p0_pins, .p1_pins,
    .periph_out, .periph_in);
  dpgm_board board (.p0_pins, .p1_pins, .ext0, .ext1, .p0_pin_in,
    .p1_pin_in);
  initial begin
    forever #25 clk = ~clk;
  end
  // ====================
  // Bus tasks and read monitor
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(negedge clk);
    sfr_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_rd = 1;
    notes.push_back(e);
    @(negedge clk);
    sfr_rd = 0;
  endtask : rd
  always @(posedge clk) rd_q <= sfr_rd;
  always @(negedge clk) begin
    if (rd_q) begin
      m = notes.pop_front();
      `CHK(sfr_rdata, m)
    end
  end
  task automatic end_of_test;
    if (notes.size() != 0) failures++;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
  // ====================
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    for (i = 0; i < 8; i++) rd(ra[i], rv[i]);
    for (i = 0; i < 20; i++) begin
      v = 8'($random(seed));
      spi_route = 2'($random(seed));
      wr(ra[2 + i % 5], v);
      rd(ra[2 + i % 5], (i % 5 > 2) ? (v & 8'h0f) : v);
      idle(4);
    end
    spi_route = 2'h0;
    wr(8'h95, 8'h00);
    wr(8'h97, 8'h00);
    // Random directions: driven pins read back the latch, others the board
    for (i = 0; i < 12; i++) begin
      dv = 8'($random(seed));
      v = 8'($random(seed));
      {ext1, ext0} = 12'($random(seed));
      g = (~dv & v) | (dv & ext0);
      wr(8'h94, dv);
      wr(8'h96, dv);
      wr(8'h80, v);
      wr(8'h90, v);
      idle(6);
      rd(8'h80, g);
      rd(8'h90, {4'h0, (~dv[3:0] & v[3:0] & 4'hb)
        | ((dv[3:0] | 4'h4) & ext1)});
      spi_route = 2'h1;
      periph_out = 5'($random(seed));
      idle(6);
      rd(8'h90, {4'h0, v[3], ext1[2], periph_out.spi_mosi,
        periph_out.spi_sck});
      // Alternate outputs on pins 0, 2 and 7; pin 1 keeps its direction
      wr(8'h95, 8'h87);
      idle(6);
      rd(8'h80, {periph_out.pwm, g[6:3], periph_out.uart_txd, g[1],
        periph_out.general_timer_output});
      `CHK(periph_in.uart_rxd, g[1])
      `CHK(periph_in.spi_miso, ext1[2])
      wr(8'h95, 8'h00);
      spi_route = 2'h0;
    end
    // Reset in mid-run must bring back the reset configuration
    {ext1, ext0} = 12'h000;
    rst_n = 0;
    idle(2);
    rst_n = 1;
    for (i = 0; i < 8; i++) rd(ra[i], rv[i]);
    // Timer and interrupt inputs with fast-changing pins
    wr(8'h95, 8'h78);
    wr(8'h97, 8'h01);
    for (i = 0; i < 80; i++) begin
      @(negedge clk);
      {ext1, ext0} = 12'($random(seed));
    end
    {ext1, ext0} = 12'hfff;
    idle(12);
    `CHK(periph_in.timer_zero_input, 1'b1)
    `CHK(periph_in.timer_one_input, 1'b1)
    `CHK(periph_in.timer_two_input, 1'b1)
    {ext1, ext0} = 12'h000;
    idle(12);
    `CHK(periph_in.external_interrupt_zero, 1'b0)
    `CHK(periph_in.timer_zero_input, 1'b0)
    `CHK(periph_in.external_interrupt_one, 1'b0)
    wr(8'h95, 8'h00);
    idle(8);
    `CHK(periph_in.external_interrupt_zero, 1'b1)
    end_of_test();
  end
endmodule : tb_dual_port_gpio_mux
`default_nettype wire
